// ---- hdl/apd_pkg.sv ----
package apd_pkg;
  localparam logic [4:0] EDGE_DOWN_MIN = 5'h02; // earliest count that powers down
  localparam logic [4:0] EDGE_WAKE = 5'h0a;     // count that commits mode
  localparam logic [4:0] EDGE_FRAME = 5'h10;    // count that ends a frame
  localparam logic [4:0] EDGE_TRACK = 5'h0d;    // falling edges before track resumes
  localparam logic [4:0] EDGE_NONE = 5'h00; // count just after select fall
  localparam logic [4:0] EDGE_SAT = 5'h1f; // count saturates here
  localparam logic [4:0] EDGE_LEAD = 5'h03; // falls that still carry leading zeros
  localparam int RESULT_MSB = 11; // top bit of the result word
  localparam logic [1:0] BOOT_IDLE = 2'h0; // strap wait count after reset
  localparam logic [1:0] BOOT_SETTLE = 2'h2; // strap flops filled
  localparam logic [11:0] RESULT_ZERO = 12'h000;

  typedef enum logic [3:0] {
    APD_NORMAL = 4'b0001,
    APD_DOWN = 4'b0010,
    APD_WAKING = 4'b0100,
    APD_WARM = 4'b1000
  } apd_mode_e;

  // sampled link pins after the synchroniser
  typedef struct packed {
    logic sel_n;
    logic sclk;
  } apd_link_s;

  // status seen by the analog wrapper
  typedef struct packed {
    logic powered;
    logic hold;
    logic result_valid;
  } apd_stat_s;
endpackage

// ---- hdl/apd_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser for the link pins
module apd_sync (
  input wire logic ref_clk, // system clock
  input wire logic arst_n, // async reset
  input wire apd_pkg::apd_link_s pin_in, // raw pins
  output apd_pkg::apd_link_s pin_out // synchronised pins
);
  apd_pkg::apd_link_s stage1;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '{sel_n: 1'b1, sclk: 1'b1};
      pin_out <= '{sel_n: 1'b1, sclk: 1'b1};
    end else begin
      stage1 <= pin_in;
      pin_out <= stage1;
    end
  end
endmodule // apd_sync

// ---- hdl/apd_seq.sv ----
`timescale 1ns/1ps
module apd_seq (
  input wire logic ref_clk, // 40 MHz system clock
  input wire logic arst_n, // async reset, active low
  input wire logic sel_n, // select pin, active low
  input wire logic sclk, // serial clock pin
  input wire logic boot_down, // strap: come up powered down
  input wire logic [11:0] conv_result, // result from analog core
  output logic serial_result_out, // serial data out
  output logic serial_result_oe, // high while data driven
  output logic analog_powered, // analog supply enable
  output logic track_hold, // high while in hold
  output logic conv_start, // pulse: sample and convert
  output logic result_valid // current frame carries valid data
);
  apd_pkg::apd_link_s pins_raw;
  apd_pkg::apd_link_s link;
  apd_pkg::apd_mode_e mode;
  logic sel_d, sclk_d, in_frame, boot_done;
  logic boot_meta, boot_sync;
  logic [1:0] boot_wait;
  logic [4:0] edges;
  logic [11:0] shreg;
  logic sel_fall, sel_rise, sclk_fall, sclk_rise;

  // count lies in the power-down window: two falls at least, short of the tenth
  function automatic logic in_down_window(input logic [4:0] count);
    logic above_min;
    logic below_wake;
    above_min = (count >= apd_pkg::EDGE_DOWN_MIN);
    below_wake = (count < apd_pkg::EDGE_WAKE);
    in_down_window = above_min && below_wake;
  endfunction

  // select rising at this count is too early to commit a wake-up
  function automatic logic before_wake(input logic [4:0] count);
    before_wake = (count < apd_pkg::EDGE_WAKE);
  endfunction

  // count has reached the end of a full frame
  function automatic logic frame_full(input logic [4:0] count);
    frame_full = (count >= apd_pkg::EDGE_FRAME);
  endfunction

  // the sixteenth fall arrives while the count still shows fifteen
  function automatic logic last_fall(input logic [4:0] count);
    last_fall = (count == apd_pkg::EDGE_FRAME - 5'h01);
  endfunction

  // raw pins bundled for the synchroniser
  assign pins_raw.sel_n = sel_n;
  assign pins_raw.sclk = sclk;

  // both link pins cross together, so their relative order is kept
  apd_sync u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pin_in(pins_raw),
    .pin_out(link)
  );

  // strap pin is asynchronous too, so it gets two flops of its own
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_meta <= 1'b0;
      boot_sync <= 1'b0;
    end else begin
      boot_meta <= boot_down;
      boot_sync <= boot_meta;
    end
  end

  // the mode is taken only once the strap flops hold the pin level
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_wait <= apd_pkg::BOOT_IDLE;
    end else if (boot_wait != apd_pkg::BOOT_SETTLE) begin
      boot_wait <= boot_wait + 2'h1;
    end
  end

  // edge detectors read only the second stage
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_d <= 1'b1;
      sclk_d <= 1'b1;
    end else begin
      sel_d <= link.sel_n;
      sclk_d <= link.sclk;
    end
  end
  // serial clock edges count only while select is low
  assign sel_fall = sel_d & ~link.sel_n;
  assign sel_rise = ~sel_d & link.sel_n;
  assign sclk_fall = sclk_d & ~link.sclk & ~link.sel_n;
  assign sclk_rise = ~sclk_d & link.sclk & ~link.sel_n;

  // falling-edge counter, cleared at each select fall
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      edges <= apd_pkg::EDGE_NONE;
    end else if (sel_fall) begin
      edges <= apd_pkg::EDGE_NONE;
    end else if (sclk_fall && edges != apd_pkg::EDGE_SAT) begin
      // saturate so a long burst cannot wrap back into the power-down window
      edges <= edges + 5'h01;
    end
  end

  // mode machine; strap caught once after reset release, the mode is arbitrary to host
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= apd_pkg::APD_NORMAL;
      boot_done <= 1'b0;
    end else if (!boot_done) begin
      if (boot_wait == apd_pkg::BOOT_SETTLE) begin
        boot_done <= 1'b1;
        mode <= boot_sync ? apd_pkg::APD_DOWN : apd_pkg::APD_NORMAL;
      end
    end else begin
      case (mode)
        apd_pkg::APD_NORMAL: begin
          // below two edges is a glitch and is ignored
          if (sel_rise && in_down_window(edges)) begin
            mode <= apd_pkg::APD_DOWN;
          end
        end
        apd_pkg::APD_DOWN: begin
          // only a select fall can start a wake-up
          if (sel_fall) begin
            mode <= apd_pkg::APD_WAKING;
          end
        end
        apd_pkg::APD_WAKING: begin
          // the tenth fall commits the wake, an earlier release drops it
          if (sel_rise && before_wake(edges)) begin
            mode <= apd_pkg::APD_DOWN;
          end else if (!before_wake(edges)) begin
            mode <= apd_pkg::APD_WARM;
          end
        end
        apd_pkg::APD_WARM: begin
          // dummy frame finishes at sixteen edges or select rise
          if (sel_rise || frame_full(edges)) begin
            mode <= apd_pkg::APD_NORMAL;
          end
        end
        default: mode <= apd_pkg::APD_NORMAL;
      endcase
    end
  end

  // waking already draws supply, so only the down mode switches it off
  assign analog_powered = (mode != apd_pkg::APD_DOWN);

  // frame tracking and output enable
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_frame <= 1'b0;
    end else if (sel_fall) begin
      in_frame <= 1'b1;
    end else if (sel_rise) begin
      in_frame <= 1'b0;
    end else if (sclk_fall && last_fall(edges)) begin
      in_frame <= 1'b0;
    end
  end
  assign serial_result_oe = in_frame;

  // result flag: a frame begun before full power carries no usable result
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_valid <= 1'b0;
    end else if (sel_fall) begin
      result_valid <= (mode == apd_pkg::APD_NORMAL);
    end
  end

  // conversion start is a handshake pulse, so it stays combinational
  assign conv_start = sel_fall & (mode == apd_pkg::APD_NORMAL);

  // track-and-hold: tracks at power-up, even when strapped down; holds while down after a frame
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      track_hold <= 1'b0;
    end else if (sel_fall) begin
      track_hold <= 1'b1;
    end else if (mode == apd_pkg::APD_WAKING && (sclk_fall || sclk_rise)) begin
      track_hold <= 1'b0;
    end else if (mode == apd_pkg::APD_NORMAL && sclk_rise && edges >= apd_pkg::EDGE_TRACK) begin
      track_hold <= 1'b0;
    end else if (sel_rise && mode == apd_pkg::APD_WAKING && before_wake(edges)) begin
      // back to hold only on a fall back to down; a committed wake keeps tracking
      track_hold <= 1'b1;
    end
  end

  // result register: loaded at select fall, shifted once the leading zeros are out
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shreg <= apd_pkg::RESULT_ZERO;
    end else if (sel_fall) begin
      shreg <= conv_result;
    end else if (sclk_fall && edges >= apd_pkg::EDGE_LEAD) begin
      shreg <= {shreg[apd_pkg::RESULT_MSB - 1:0], 1'b0};
    end
  end

  // data pin: first zero at select fall, three more zeros, then msb first
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_result_out <= 1'b0;
    end else if (sel_fall) begin
      serial_result_out <= 1'b0;
    end else if (sclk_fall) begin
      if (edges < apd_pkg::EDGE_LEAD) begin
        serial_result_out <= 1'b0;
      end else begin
        serial_result_out <= shreg[apd_pkg::RESULT_MSB];
      end
    end
  end
endmodule // apd_seq

// ---- test/apd_seq_checker.sv ----
`timescale 1ns/1ps
module apd_seq_checker (
  input wire logic ref_clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic sel_n, // select pin
  input wire logic serial_result_oe, // data drive enable
  input wire logic analog_powered, // analog supply enable
  input wire logic track_hold, // high while in hold
  input wire logic conv_start, // conversion start pulse
  input wire logic result_valid // frame carries valid data
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // conversion start seen as a select-fall step followed by hold
  sequence s_start;
    conv_start && !sel_n;
  endsequence
  property p_start_pwr; conv_start |-> analog_powered; endproperty
  a_start_pwr: assert property (p_start_pwr) else $error("start while down");
  property p_start_pulse; conv_start |=> !conv_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_start_hold; s_start |-> ##[0:2] track_hold; endproperty
  a_start_hold: assert property (p_start_hold) else $error("no hold at start");
  property p_down_quiet; !analog_powered |-> !serial_result_oe; endproperty
  a_down_quiet: assert property (p_down_quiet) else $error("driving while down");
  property p_down_rise; $fell(analog_powered) |-> sel_n; endproperty
  a_down_rise: assert property (p_down_rise) else $error("down without select rise");
  property p_valid_pwr; $rose(result_valid) |-> analog_powered; endproperty
  a_valid_pwr: assert property (p_valid_pwr) else $error("valid while down");
  property p_valid_sel; $rose(result_valid) |-> !sel_n; endproperty
  a_valid_sel: assert property (p_valid_sel) else $error("valid outside frame");
  property p_oe_sel; $rose(serial_result_oe) |-> !sel_n; endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("drive outside frame");
endmodule // apd_seq_checker
bind apd_seq apd_seq_checker chk (.ref_clk(ref_clk), .arst_n(arst_n), .sel_n(sel_n),
  .serial_result_oe(serial_result_oe), .analog_powered(analog_powered), .track_hold(track_hold),
  .conv_start(conv_start), .result_valid(result_valid));

// ---- test/apd_host.sv ----
`timescale 1ns/1ps
module apd_host (
  input wire logic ref_clk, // system clock
  input wire logic sdo, // data from converter
  input wire logic vld, // valid flag from converter
  input wire logic oe, // drive enable from converter
  output logic sel_n, // select, active low
  output logic sclk, // serial clock, idles high
  output logic [15:0] rx, // bits shifted in
  output logic rx_vld, // valid seen in frame
  output logic rx_oe // drive enable seen before each fall
);
  initial begin
    sel_n = 1'b1;
    sclk = 1'b1;
    rx = 16'h0000;
    rx_vld = 1'b0;
    rx_oe = 1'b0;
  end
  // one frame of n falls; clock stands still outside frames
  task automatic frame(input int n);
    @(posedge ref_clk) sel_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      rx <= {rx[14:0], sdo}; // bit settled just before its fall
      rx_vld <= vld;
      rx_oe <= oe;
      sclk <= 1'b0;
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b1;
      repeat (4) @(posedge ref_clk);
    end
    sel_n <= 1'b1;
    repeat (40) @(posedge ref_clk); // quiet gap after release
  endtask
endmodule // apd_host

// ---- test/apd_seq_test.sv ----
`timescale 1ns/1ps
module apd_seq_test;
  logic ref_clk;
  logic arst_n;
  logic boot_down;
  logic [11:0] conv_result;
  logic sel_n, sclk, sdo, oe, pwr, hold, start, vld, rx_vld, rx_oe;
  logic [15:0] rx;
  int error_cnt = 0;
  int num_checks = 0;
  int starts = 0;
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  // count start pulses; only frames begun fully powered may raise one
  always @(posedge ref_clk) begin
    if (start === 1'b1) begin
      starts <= starts + 1;
    end
  end
  apd_seq dut (.ref_clk(ref_clk), .arst_n(arst_n), .sel_n(sel_n), .sclk(sclk), .boot_down(boot_down),
    .conv_result(conv_result), .serial_result_out(sdo), .serial_result_oe(oe), .analog_powered(pwr),
    .track_hold(hold), .conv_start(start), .result_valid(vld));
  apd_host host (.ref_clk(ref_clk), .sdo(sdo), .vld(vld), .oe(oe), .sel_n(sel_n), .sclk(sclk), .rx(rx),
    .rx_vld(rx_vld), .rx_oe(rx_oe));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic down);
    @(posedge ref_clk) arst_n <= 1'b0;
    boot_down <= down;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
  // normal start, full frame, then short and aborted frames
  task automatic t_normal();
    do_reset(1'b0);
    chk("pwr", 16'h1, pwr);
    chk("hold", 16'h0, hold);
    host.frame(16);
    chk("data", {4'h0, conv_result}, rx);
    chk("oe seen", 16'h1, rx_oe);
    chk("oe", 16'h0, oe);
    host.frame(1);
    chk("pwr", 16'h1, pwr);
    host.frame(12);
    chk("pwr", 16'h1, pwr);
    chk("oe", 16'h0, oe);
    chk("starts", 16'h3, 16'(starts));
    $display("normal test done");
  endtask
  // power down at the last count, short burst, then wake
  task automatic t_down();
    host.frame(9); // release after the ninth fall powers down
    chk("pwr", 16'h0, pwr);
    chk("oe", 16'h0, oe);
    chk("hold", 16'h1, hold);
    host.frame(8);
    chk("pwr", 16'h0, pwr);
    chk("hold", 16'h1, hold);
    host.frame(16); // one dummy cycle suffices
    chk("pwr", 16'h1, pwr);
    chk("vld", 16'h0, rx_vld);
    chk("hold", 16'h0, hold);
    conv_result <= 12'h3c9;
    host.frame(16);
    chk("vld", 16'h1, rx_vld);
    chk("data", 16'h03c9, rx);
    chk("starts", 16'h5, 16'(starts));
    $display("down test done");
  endtask
  // strap start powered down, dummy cycle at once
  task automatic t_strap();
    do_reset(1'b1);
    chk("pwr", 16'h0, pwr);
    host.frame(16);
    chk("pwr", 16'h1, pwr);
    host.frame(9);
    chk("pwr", 16'h0, pwr);
    host.frame(11); // release one fall after the tenth
    chk("pwr", 16'h1, pwr);
    chk("hold", 16'h0, hold);
    conv_result <= 12'h6e1;
    host.frame(16);
    chk("vld", 16'h1, rx_vld);
    chk("data", 16'h06e1, rx);
    chk("starts", 16'h7, 16'(starts));
    $display("strap test done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    boot_down = 1'b0;
    conv_result = 12'ha5c;
    t_normal();
    t_down();
    t_strap();
    end_sim();
  end
endmodule // apd_seq_test
